// ===== ocd_pkg.sv
`default_nettype none
package ocd_pkg;
  // ==========================================================
  // Register map
  localparam int OCD_NUM_REGS = 14;
  localparam int OCD_NUM_PECL = 3;
  localparam int OCD_NUM_LVCH = 2;
  typedef logic [7:0] ocd_byte_t;
  typedef logic [9:0] ocd_addr_t;
  localparam ocd_addr_t OCD_REG_ADDR [OCD_NUM_REGS] = '{
    10'h190, 10'h191, 10'h193, 10'h194, 10'h196, 10'h197, 10'h199,
    10'h19A, 10'h19B, 10'h19C, 10'h19E, 10'h19F, 10'h1A0, 10'h1A1};
  localparam ocd_byte_t OCD_REG_RESET [OCD_NUM_REGS] = '{
    8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam ocd_addr_t OCD_UPDATE_ADDR = 10'h232;
  localparam int OCD_UPDATE_BIT = 0;
  localparam logic [4:0] OCD_NO_REG = 5'h1F;
  // ==========================================================
  // Field layout
  localparam int OCD_PECL_BASE   = 0;
  localparam int OCD_PECL_STRIDE = 2;
  localparam int OCD_LVCH_BASE   = 6;
  localparam int OCD_LVCH_STRIDE = 4;
  localparam int OCD_LV_S1_CNT   = 0;
  localparam int OCD_LV_PHASE    = 1;
  localparam int OCD_LV_S2_CNT   = 2;
  localparam int OCD_LV_CTRL     = 3;
  localparam int OCD_NIB         = 4;
  localparam int OCD_LOW_LSB     = 4;
  localparam int OCD_HIGH_LSB    = 0;
  localparam int OCD_PC_BYPASS   = 7;
  localparam int OCD_PC_NOSYNC   = 6;
  localparam int OCD_PC_FORCE    = 5;
  localparam int OCD_PC_START    = 4;
  localparam int OCD_PC_PH_LSB   = 0;
  localparam int OCD_LC_BYP2     = 5;
  localparam int OCD_LC_BYP1     = 4;
  localparam int OCD_LC_NOSYNC   = 3;
  localparam int OCD_LC_FORCE    = 2;
  localparam int OCD_LC_START2   = 1;
  localparam int OCD_LC_START1   = 0;
  localparam int OCD_LV_PH2_LSB  = 4;
  localparam int OCD_LV_PH1_LSB  = 0;
  localparam logic [5:0] OCD_DIV_EXTRA = 6'h02;
  typedef enum {OCD_RUN, OCD_PHASE, OCD_HOLD} ocd_state_t;
endpackage
`default_nettype wire

// ===== ocd_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ocd_cfg_if;
  logic [3:0] low_cnt;
  logic [3:0] high_cnt;
  logic [3:0] phase;
  logic       bypass;
  logic       nosync;
  logic       force_hi;
  logic       start_hi;
  modport src (output low_cnt, high_cnt, phase, bypass, nosync, force_hi, start_hi);
  modport stage (input low_cnt, high_cnt, phase, bypass, nosync, force_hi, start_hi);
endinterface
`default_nettype wire

// ===== ocd_stage.sv
`timescale 1ns/1ps
`default_nettype none
module ocd_stage
  import ocd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  ocd_cfg_if.stage  cfg,
  input  wire logic in_tick,
  input  wire logic in_lvl,
  input  wire logic hold,
  input  wire logic restart,
  output logic      out_lvl,
  output logic      out_tick
);
  // ==========================================================
  // Divider stage
  // Each half period is fixed by the ratio alone, so the split between the
  // two count fields never shows in the duty cycle. Odd ratios give the
  // high half one input cycle more, the best an edge counter can do.
  logic [5:0] div_ratio;
  ocd_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [3:0] ph_reg;
  logic       out_reg;
  logic       out_d_reg;

  function automatic logic [5:0] half_len(input logic lvl, input logic [5:0] d);
    return lvl ? (d - {1'b0, d[5:1]}) : {1'b0, d[5:1]};
  endfunction

  assign div_ratio = {2'b00, cfg.low_cnt} + {2'b00, cfg.high_cnt} + OCD_DIV_EXTRA;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= OCD_RUN;
      cnt_reg   <= 6'h01;
      ph_reg    <= 4'h0;
      out_reg   <= 1'b0;
    end
    else if (cfg.bypass)
    begin
      out_reg   <= in_lvl;
      state_reg <= OCD_RUN;
      cnt_reg   <= 6'h01;
    end
    else if (hold && cfg.nosync)
      out_reg <= cfg.force_hi;
    else if (hold)
    begin
      state_reg <= OCD_HOLD;
      out_reg   <= cfg.start_hi;
    end
    else if (restart && !cfg.nosync)
    begin
      out_reg   <= cfg.start_hi;
      cnt_reg   <= half_len(cfg.start_hi, div_ratio);
      ph_reg    <= cfg.phase;
      state_reg <= (cfg.phase == 4'h0) ? OCD_RUN : OCD_PHASE;
    end
    else if (in_tick)
    begin
      case (state_reg)
        OCD_PHASE:
        begin
          if (ph_reg == 4'h1)
            state_reg <= OCD_RUN;
          ph_reg <= ph_reg - 4'h1;
        end
        OCD_RUN:
        begin
          if (cnt_reg <= 6'h01)
          begin
            out_reg <= ~out_reg;
            cnt_reg <= half_len(~out_reg, div_ratio);
          end
          else
            cnt_reg <= cnt_reg - 6'h01;
        end
        default:
          state_reg <= OCD_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      out_d_reg <= 1'b0;
    else
      out_d_reg <= out_reg;
  end

  assign out_lvl  = out_reg;
  assign out_tick = out_reg & ~out_d_reg;

  a_bypass_follow: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.bypass |=> out_reg == $past(in_lvl))
    else $error("Bypassed stage does not follow its input.");
  a_hold_static: assert property (@(posedge clk) disable iff (!rst_b)
    (hold && !cfg.nosync && !cfg.bypass) |=> out_reg == $past(cfg.start_hi))
    else $error("Held stage is not at its static level.");
  a_force_level: assert property (@(posedge clk) disable iff (!rst_b)
    (hold && cfg.nosync && !cfg.bypass) |=> out_reg == $past(cfg.force_hi))
    else $error("Sync-ignoring stage is not at its forced level.");
  a_nosync_ignores: assert property (@(posedge clk) disable iff (!rst_b)
    (restart && cfg.nosync && !cfg.bypass && state_reg == OCD_RUN)
      |=> state_reg == OCD_RUN)
    else $error("Sync-ignoring stage reacted to a restart.");
  a_restart_start: assert property (@(posedge clk) disable iff (!rst_b)
    (restart && !hold && !cfg.nosync && !cfg.bypass)
      |=> out_reg == $past(cfg.start_hi) && ph_reg == $past(cfg.phase))
    else $error("Restart did not load start level and offset.");
  a_half_reload: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == OCD_RUN && in_tick && cnt_reg == 6'h01 && !cfg.bypass && !hold && !restart)
      |=> out_reg != $past(out_reg) && cnt_reg == half_len(out_reg, $past(div_ratio)))
    else $error("Half period reload is wrong.");
endmodule
`default_nettype wire

// ===== ocd_dividers.sv
// Overview of operation
// - A single-stage divider divides by low count plus high count plus two, low in [7:4].
// - Duty-cycle correction is always on, so the count split never changes the duty.
// - Control bit 7 bypasses a single-stage divider and passes its input to the output.
// - After reset the first single-stage divider is bypassed and the other two divide.
// - A clear sync-ignore bit makes the divider obey the sync signal; set ignores its release and forces the level while held.
// - The force-level bit sets the static level, effective only with sync-ignore set.
// - The start-level bit sets whether the output starts high or low on toggling.
// - Every stage has a four-bit phase offset that resets to zero.
// - A dual-stage channel cascades two stages, each dividing by its counts plus two.
// - Bits 5 and 4 bypass the second and first stage of a dual-stage channel.
// - A dual-stage channel shares sync-ignore at bit 3 and force-level at bit 2.
// - Bits 1 and 0 give the second and first stage their own start levels.
// - The second dual-stage channel repeats the first at its own four registers.
// - Sync held holds participating dividers static; its release restarts them.
// - Writes land in buffer registers and go active when update-all is written one.
`timescale 1ns/1ps
`default_nettype none
module ocd_dividers
  import ocd_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       SYNC_B,
  input  wire logic       DIST_CLK,
  input  wire logic       REG_WR,
  input  wire logic [9:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic      [2:0] PECL_OUT,
  output logic      [1:0] LVCH_OUT
);
  // ==========================================================
  // Pin synchronisers
  // Bit 0 carries the sync request, bit 1 the divider input clock. The
  // input clock is sampled, so it must stay below half of REF_CLK.
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s3_reg;
  logic       sync_hold;
  logic       sync_restart;
  logic       dist_tick;
  logic       dist_lvl;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_s1_reg <= 2'h1;
      pin_s2_reg <= 2'h1;
      pin_s3_reg <= 2'h1;
    end
    else
    begin
      pin_s1_reg <= {DIST_CLK, SYNC_B};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign sync_hold    = ~pin_s2_reg[0];
  assign sync_restart = pin_s2_reg[0] & ~pin_s3_reg[0];
  assign dist_lvl     = pin_s2_reg[1];
  assign dist_tick    = pin_s2_reg[1] & ~pin_s3_reg[1];

  // ==========================================================
  // Register decode
  function automatic logic [4:0] reg_index(input ocd_addr_t addr);
    logic [4:0] idx;
    idx = OCD_NO_REG;
    for (int i = 0; i < OCD_NUM_REGS; i++)
    begin
      if (addr == OCD_REG_ADDR[i])
        idx = 5'(i);
    end
    return idx;
  endfunction

  logic [4:0] wr_idx;
  logic [4:0] rd_idx;

  assign wr_idx = reg_index(REG_ADDR);
  assign rd_idx = reg_index(REG_ADDR);

  // ==========================================================
  // Buffer and active registers
  // Software only ever sees the buffer copy; the dividers only ever see the
  // active copy, so a half-written set of fields can never glitch a channel.
  ocd_byte_t buf_reg [OCD_NUM_REGS];
  ocd_byte_t act_reg [OCD_NUM_REGS];
  logic      upd_reg;
  logic [7:0] rdata_reg;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < OCD_NUM_REGS; i++)
        buf_reg[i] <= OCD_REG_RESET[i];
    end
    else if (REG_WR && wr_idx != OCD_NO_REG)
      buf_reg[wr_idx[3:0]] <= REG_WDATA;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      upd_reg <= 1'b0;
    else
      upd_reg <= REG_WR && (REG_ADDR == OCD_UPDATE_ADDR) && REG_WDATA[OCD_UPDATE_BIT];
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < OCD_NUM_REGS; i++)
        act_reg[i] <= OCD_REG_RESET[i];
    end
    else if (upd_reg)
    begin
      for (int i = 0; i < OCD_NUM_REGS; i++)
        act_reg[i] <= buf_reg[i];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_reg <= 8'h00;
    else if (rd_idx == OCD_NO_REG)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= buf_reg[rd_idx[3:0]];
  end

  assign REG_RDATA = rdata_reg;

  // ==========================================================
  // Single-stage channels
  logic [2:0] pecl_lvl;

  generate
    for (genvar p = 0; p < OCD_NUM_PECL; p++)
    begin : g_pecl
      localparam int CI = OCD_PECL_BASE + p * OCD_PECL_STRIDE;
      ocd_cfg_if cfg ();

      assign cfg.low_cnt  = act_reg[CI][OCD_LOW_LSB +: OCD_NIB];
      assign cfg.high_cnt = act_reg[CI][OCD_HIGH_LSB +: OCD_NIB];
      assign cfg.bypass   = act_reg[CI + 1][OCD_PC_BYPASS];
      assign cfg.nosync   = act_reg[CI + 1][OCD_PC_NOSYNC];
      assign cfg.force_hi = act_reg[CI + 1][OCD_PC_FORCE];
      assign cfg.start_hi = act_reg[CI + 1][OCD_PC_START];
      assign cfg.phase    = act_reg[CI + 1][OCD_PC_PH_LSB +: OCD_NIB];

      ocd_stage u_stage (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .cfg      (cfg.stage),
        .in_tick  (dist_tick),
        .in_lvl   (dist_lvl),
        .hold     (sync_hold),
        .restart  (sync_restart),
        .out_lvl  (pecl_lvl[p]),
        .out_tick ()
      );
    end
  endgenerate

  assign PECL_OUT = pecl_lvl;

  // ==========================================================
  // Dual-stage channels
  // Both channels come from one loop, so their layouts cannot drift apart.
  logic [1:0] lvch_lvl;

  generate
    for (genvar c = 0; c < OCD_NUM_LVCH; c++)
    begin : g_lvch
      localparam int CB = OCD_LVCH_BASE + c * OCD_LVCH_STRIDE;
      ocd_cfg_if s1cfg ();
      ocd_cfg_if s2cfg ();
      logic s1_lvl;
      logic s1_tick;

      assign s1cfg.low_cnt  = act_reg[CB + OCD_LV_S1_CNT][OCD_LOW_LSB +: OCD_NIB];
      assign s1cfg.high_cnt = act_reg[CB + OCD_LV_S1_CNT][OCD_HIGH_LSB +: OCD_NIB];
      assign s1cfg.phase    = act_reg[CB + OCD_LV_PHASE][OCD_LV_PH1_LSB +: OCD_NIB];
      assign s1cfg.bypass   = act_reg[CB + OCD_LV_CTRL][OCD_LC_BYP1];
      assign s1cfg.nosync   = act_reg[CB + OCD_LV_CTRL][OCD_LC_NOSYNC];
      assign s1cfg.force_hi = act_reg[CB + OCD_LV_CTRL][OCD_LC_FORCE];
      assign s1cfg.start_hi = act_reg[CB + OCD_LV_CTRL][OCD_LC_START1];

      assign s2cfg.low_cnt  = act_reg[CB + OCD_LV_S2_CNT][OCD_LOW_LSB +: OCD_NIB];
      assign s2cfg.high_cnt = act_reg[CB + OCD_LV_S2_CNT][OCD_HIGH_LSB +: OCD_NIB];
      assign s2cfg.phase    = act_reg[CB + OCD_LV_PHASE][OCD_LV_PH2_LSB +: OCD_NIB];
      assign s2cfg.bypass   = act_reg[CB + OCD_LV_CTRL][OCD_LC_BYP2];
      assign s2cfg.nosync   = act_reg[CB + OCD_LV_CTRL][OCD_LC_NOSYNC];
      assign s2cfg.force_hi = act_reg[CB + OCD_LV_CTRL][OCD_LC_FORCE];
      assign s2cfg.start_hi = act_reg[CB + OCD_LV_CTRL][OCD_LC_START2];

      ocd_stage u_first (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .cfg      (s1cfg.stage),
        .in_tick  (dist_tick),
        .in_lvl   (dist_lvl),
        .hold     (sync_hold),
        .restart  (sync_restart),
        .out_lvl  (s1_lvl),
        .out_tick (s1_tick)
      );

      // The second stage counts first-stage rising edges, flagged in the same
      // REF_CLK cycle in which the first-stage output goes high.
      ocd_stage u_second (
        .clk      (REF_CLK),
        .rst_b    (RST_B),
        .cfg      (s2cfg.stage),
        .in_tick  (s1_tick),
        .in_lvl   (s1_lvl),
        .hold     (sync_hold),
        .restart  (sync_restart),
        .out_lvl  (lvch_lvl[c]),
        .out_tick ()
      );
    end
  endgenerate

  assign LVCH_OUT = lvch_lvl;

  // ==========================================================
  // Checks
  a_update_copy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd_reg |=> act_reg[1] == $past(buf_reg[1]) && act_reg[9] == $past(buf_reg[9]))
    else $error("Update did not copy buffers to active registers.");

  a_active_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !upd_reg |=> act_reg[1] == $past(act_reg[1]) && act_reg[13] == $past(act_reg[13]))
    else $error("Active register changed without an update.");

  a_update_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (REG_WR && REG_ADDR == OCD_UPDATE_ADDR && REG_WDATA[OCD_UPDATE_BIT]) ##1 !REG_WR
      |=> !upd_reg)
    else $error("Update command did not clear itself.");

  a_restart_once: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_restart |=> !sync_restart && !sync_hold ##0 $past(pin_s3_reg[0]) == 1'b0)
    else $error("Sync restart is not a single pulse at release.");

  // ==========================================================
  // Output and register checks
  // Register indices follow the order of the address table in the package.
  a_rdata_mapped: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    rd_idx != OCD_NO_REG
      |=> REG_RDATA == $past(buf_reg[rd_idx[3:0]]))
    else $error("Read data is not the buffer register.");

  a_rdata_unmapped: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    rd_idx == OCD_NO_REG
      |=> REG_RDATA == 8'h00)
    else $error("Unmapped read did not return zero.");

  a_buffer_write: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    REG_WR && wr_idx != OCD_NO_REG
      |=> buf_reg[$past(wr_idx[3:0])] == $past(REG_WDATA))
    else $error("Write did not land in the buffer register.");

  a_update_lvch: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    upd_reg
      |=> act_reg[6] == $past(buf_reg[6]) && act_reg[13] == $past(buf_reg[13]))
    else $error("Update did not copy dual-stage registers.");

  a_div0_bypass: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_reg[1][OCD_PC_BYPASS]
      |=> PECL_OUT[0] == $past(dist_lvl))
    else $error("Bypassed first divider does not pass its input.");

  a_div1_bypass: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_reg[3][OCD_PC_BYPASS]
      |=> PECL_OUT[1] == $past(dist_lvl))
    else $error("Bypassed second divider does not pass its input.");

  a_div2_bypass: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_reg[5][OCD_PC_BYPASS]
      |=> PECL_OUT[2] == $past(dist_lvl))
    else $error("Bypassed third divider does not pass its input.");

  a_lva_bypass: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_reg[9][OCD_LC_BYP2] && act_reg[9][OCD_LC_BYP1] && $past(act_reg[9][OCD_LC_BYP1])
      |=> LVCH_OUT[0] == $past(dist_lvl, 2))
    else $error("Fully bypassed first dual channel does not pass its input.");

  a_lvb_bypass: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    act_reg[13][OCD_LC_BYP2] && act_reg[13][OCD_LC_BYP1] && $past(act_reg[13][OCD_LC_BYP1])
      |=> LVCH_OUT[1] == $past(dist_lvl, 2))
    else $error("Fully bypassed second dual channel does not pass its input.");

  a_div0_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[1][OCD_PC_BYPASS] && !act_reg[1][OCD_PC_NOSYNC]
      |=> PECL_OUT[0] == $past(act_reg[1][OCD_PC_START]))
    else $error("Held first divider is not at its start level.");

  a_div1_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[3][OCD_PC_BYPASS] && !act_reg[3][OCD_PC_NOSYNC]
      |=> PECL_OUT[1] == $past(act_reg[3][OCD_PC_START]))
    else $error("Held second divider is not at its start level.");

  a_div2_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[5][OCD_PC_BYPASS] && !act_reg[5][OCD_PC_NOSYNC]
      |=> PECL_OUT[2] == $past(act_reg[5][OCD_PC_START]))
    else $error("Held third divider is not at its start level.");

  a_div1_force: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[3][OCD_PC_BYPASS] && act_reg[3][OCD_PC_NOSYNC]
      |=> PECL_OUT[1] == $past(act_reg[3][OCD_PC_FORCE]))
    else $error("Second divider is not at its forced level.");

  a_div2_force: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[5][OCD_PC_BYPASS] && act_reg[5][OCD_PC_NOSYNC]
      |=> PECL_OUT[2] == $past(act_reg[5][OCD_PC_FORCE]))
    else $error("Third divider is not at its forced level.");

  a_lva_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[9][OCD_LC_BYP2] && !act_reg[9][OCD_LC_NOSYNC]
      |=> LVCH_OUT[0] == $past(act_reg[9][OCD_LC_START2]))
    else $error("Held first dual channel is not at its start level.");

  a_lva_force: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[9][OCD_LC_BYP2] && act_reg[9][OCD_LC_NOSYNC]
      |=> LVCH_OUT[0] == $past(act_reg[9][OCD_LC_FORCE]))
    else $error("First dual channel is not at its forced level.");

  a_lvb_force: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    sync_hold && !act_reg[13][OCD_LC_BYP2] && act_reg[13][OCD_LC_NOSYNC]
      |=> LVCH_OUT[1] == $past(act_reg[13][OCD_LC_FORCE]))
    else $error("Second dual channel is not at its forced level.");
endmodule
`default_nettype wire

// ===== test_output_channel_clock_dividers.sv
`timescale 1ns/1ps
`default_nettype none
module test_output_channel_clock_dividers
  import ocd_pkg::*;
;
  // ==========================================================
  // Stimulus and observation
  localparam int IN_HALF = 4;
  localparam int IN_PER  = 2 * IN_HALF;
  localparam int LIMIT   = 40000;
  logic        ref_clk;
  logic        rst_b;
  logic        sync_b;
  logic        dist_clk = 1'b0;
  logic        reg_wr;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [2:0]  pecl_out;
  logic [1:0]  lvch_out;
  logic [4:0]  outs;
  logic [31:0] seed;
  int          bad_count;
  int          n_checks;
  int          cycles = 0;
  int          half_cnt = 0;

  assign outs = {lvch_out, pecl_out};

  ocd_dividers u_ocd_dividers (
    .REF_CLK   (ref_clk),
    .RST_B     (rst_b),
    .SYNC_B    (sync_b),
    .DIST_CLK  (dist_clk),
    .REG_WR    (reg_wr),
    .REG_ADDR  (reg_addr),
    .REG_WDATA (reg_wdata),
    .REG_RDATA (reg_rdata),
    .PECL_OUT  (pecl_out),
    .LVCH_OUT  (lvch_out)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // The divider input is made synchronous to the bench clock so that every
  // measured period is an exact multiple of IN_PER.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (half_cnt == IN_HALF - 1)
    begin
      half_cnt <= 0;
      dist_clk <= ~dist_clk;
    end
    else
      half_cnt <= half_cnt + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic int ratio(input logic [7:0] c);
    return int'(c[7:4]) + int'(c[3:0]) + 2;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    v = reg_rdata;
  endtask

  task automatic update();
    wr(OCD_UPDATE_ADDR, 8'h01);
    repeat (4) @(posedge ref_clk);
  endtask

  // Skips the first period after a change, since the restart phase is unknown.
  task automatic check_div(input int b, input int per_exp, input int hi_exp, input string name);
    int   rises;
    int   n;
    int   per;
    int   hi;
    logic prev;
    rises = 0;
    n = 0;
    per = 0;
    hi = 0;
    prev = outs[b];
    while (rises < 3 && n < 20000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (outs[b] === 1'b1 && prev === 1'b0)
        rises++;
      if (rises == 2)
        per++;
      if (rises == 2 && outs[b] === 1'b1)
        hi++;
      prev = outs[b];
    end
    check({name, " period"}, per_exp, per);
    check({name, " high time"}, hi_exp, hi);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [9:0] base;
    int         d;
    int         d1;
    int         d2;
    int         t1;
    int         t2;
    seed = 32'h4E8A;
    rst_b = 1'b0;
    sync_b = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    bad_count = 0;
    n_checks = 0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < OCD_NUM_REGS; i++)
    begin
      rd(OCD_REG_ADDR[i], v);
      check("reset value", (OCD_REG_ADDR[i] == 10'h191) ? 8'h80 : 8'h00, v);
    end
    check_div(0, IN_PER, IN_HALF, "div0 after reset");
    check_div(1, 2 * IN_PER, IN_PER, "div1 after reset");
    for (int i = 0; i < OCD_NUM_REGS; i++)
    begin
      seed = xs(seed);
      wr(OCD_REG_ADDR[i], seed[7:0]);
      rd(OCD_REG_ADDR[i], v);
      check("readback", seed[7:0], v);
      wr(OCD_REG_ADDR[i], (OCD_REG_ADDR[i] == 10'h191) ? 8'h80 : 8'h00);
    end
    wr(10'h192, 8'hA5);
    rd(10'h192, v);
    check("unmapped read", 8'h00, v);
    rd(OCD_UPDATE_ADDR, v);
    check("update address read", 8'h00, v);
    wr(10'h193, 8'h22);
    check_div(1, 2 * IN_PER, IN_PER, "div1 before update");
    update();
    check_div(1, 6 * IN_PER, 3 * IN_PER, "div1 after update");
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      c = (i == 0) ? 8'hFF : (i == 1) ? 8'h0F : (i == 2) ? 8'hF0 : seed[7:0];
      d = ratio(c);
      wr(10'h196, c);
      update();
      check_div(2, d * IN_PER, (d - d / 2) * IN_PER, "div2 ratio");
    end
    wr(10'h197, 8'h80);
    update();
    check_div(2, IN_PER, IN_HALF, "div2 bypass");
    for (int ch = 0; ch < 2; ch++)
    begin
      base = (ch == 0) ? 10'h199 : 10'h19E;
      seed = xs(seed);
      c1 = seed[7:0] & 8'h31;
      c2 = seed[15:8] & 8'h13;
      d1 = ratio(c1);
      d2 = ratio(c2);
      wr(base, c1);
      wr(base + 10'h002, c2);
      wr(base + 10'h003, 8'h00);
      update();
      check_div(3 + ch, d1 * d2 * IN_PER, (d2 - d2 / 2) * d1 * IN_PER, "cascade");
      wr(base + 10'h003, 8'h10);
      update();
      check_div(3 + ch, d2 * IN_PER, (d2 - d2 / 2) * IN_PER, "stage1 bypass");
      wr(base + 10'h003, 8'h20);
      update();
      check_div(3 + ch, d1 * IN_PER, (d1 - d1 / 2) * IN_PER, "stage2 bypass");
    end
    wr(10'h193, 8'h00);
    wr(10'h194, 8'h10);
    wr(10'h196, 8'h00);
    wr(10'h197, 8'h13);
    wr(10'h19C, 8'h00);
    wr(10'h1A1, 8'h0C);
    update();
    @(posedge ref_clk);
    sync_b <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      repeat (2 * IN_PER) @(posedge ref_clk);
      #1;
      check("held start high div1", 1'b1, pecl_out[1]);
      check("held start high div2", 1'b1, pecl_out[2]);
      check("held start low dual", 1'b0, lvch_out[0]);
      check("nosync forced high", 1'b1, lvch_out[1]);
    end
    @(posedge ref_clk);
    sync_b <= 1'b1;
    t1 = -1;
    t2 = -1;
    for (int n = 0; n < 400 && (t1 < 0 || t2 < 0); n++)
    begin
      @(posedge ref_clk);
      #1;
      if (t1 < 0 && pecl_out[1] !== 1'b1)
        t1 = n;
      if (t2 < 0 && pecl_out[2] !== 1'b1)
        t2 = n;
    end
    check("phase offset delay", 3 * IN_PER, t2 - t1);
    summarize();
  end
endmodule
`default_nettype wire
